// [core/lseu_core.sv]
`timescale 1ns/1ps
// Overview of operation
// - load direct: absolute address, two cycles, flags kept
// - indirect load one cycle, optional post increment
// - pre-decrement load: decrement, then read, two cycles
// - displaced load: pointer plus offset, two cycles
// - direct write: absolute address, two cycles
// - indirect write one cycle, optional post increment
// - pre-decrement write: decrement first, two cycles
// - displaced write: pointer plus offset, two cycles
// - program read via pointer_c, three cycles
// - extended program read prefixes page extension, three cycles
module lseu_core (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rst_n,
    // instruction side
    input  wire logic        issue,
    input  wire logic [3:0]  op,
    input  wire logic [1:0]  ptr_sel,
    input  wire logic [4:0]  dest_reg,
    input  wire logic [4:0]  source_reg,
    input  wire logic [15:0] abs_addr,
    input  wire logic [5:0]  displacement,
    input  wire logic [7:0]  source_data,
    input  wire logic        page_ext_wr,
    input  wire logic [7:0]  page_ext_value,
    // instruction side results
    output logic             busy,
    output logic             done,
    output logic             reg_wr,
    output logic [4:0]       reg_wr_addr,
    output logic [7:0]       reg_wr_data,
    output logic [7:0]       program_page_ext,
    // data space
    output logic             data_rd,
    output logic             data_wr,
    output logic [15:0]      data_addr,
    output logic [7:0]       data_wdata,
    input  wire logic [7:0]  data_rdata,
    input  wire logic        data_wait,
    // program flash
    output logic             prog_rd,
    output logic [23:0]      prog_addr,
    input  wire logic [7:0]  prog_rdata
);
    typedef enum logic [1:0] {
        PH_IDLE,
        PH_ACCESS,
        PH_FINISH
    } lseu_state_t;

    lseu_state_t         state;
    lseu_pkg::lseu_op_t  cur_op;
    logic [1:0]          cur_ptr;
    logic [4:0]          cur_dest;
    logic [1:0]          cycle;
    logic [1:0]          need;
    logic [15:0]         ptr_a;
    logic [15:0]         ptr_b;
    logic [15:0]         ptr_c;
    logic [15:0]         sel_ptr;
    logic                ptr_wr;
    logic [1:0]          ptr_wr_sel;
    logic [15:0]         ptr_wr_value;
    lseu_pkg::lseu_op_t  new_op;

    assign new_op = lseu_pkg::lseu_op_t'(op);

    function automatic logic [15:0] pick_ptr(input logic [1:0] s, input logic [15:0] a,
                                             input logic [15:0] b, input logic [15:0] c);
        unique case (lseu_pkg::lseu_ptr_t'(s))
            lseu_pkg::PTR_A: pick_ptr = a;
            lseu_pkg::PTR_B: pick_ptr = b;
            default:         pick_ptr = c;
        endcase
    endfunction : pick_ptr

    function automatic logic [1:0] cycles_of(input lseu_pkg::lseu_op_t o);
        unique case (o)
            lseu_pkg::OP_LOAD_INDIRECT, lseu_pkg::OP_LOAD_POST_INC,
            lseu_pkg::OP_WRITE_INDIRECT, lseu_pkg::OP_WRITE_POST_INC:
                cycles_of = 2'(lseu_pkg::CYC_INDIRECT);
            lseu_pkg::OP_LOAD_PRE_DEC, lseu_pkg::OP_WRITE_PRE_DEC:
                cycles_of = 2'(lseu_pkg::CYC_PRE_DEC);
            lseu_pkg::OP_LOAD_DISPLACED, lseu_pkg::OP_WRITE_DISPLACED:
                cycles_of = 2'(lseu_pkg::CYC_DISPLACED);
            lseu_pkg::OP_READ_PROGRAM_MEM, lseu_pkg::OP_READ_PROGRAM_MEM_INC,
            lseu_pkg::OP_READ_PROGRAM_MEM_EXT, lseu_pkg::OP_READ_PROGRAM_MEM_EXT_INC:
                cycles_of = 2'(lseu_pkg::CYC_PROGRAM);
            default:
                cycles_of = 2'(lseu_pkg::CYC_DIRECT);
        endcase
    endfunction : cycles_of

    function automatic logic is_load(input lseu_pkg::lseu_op_t o);
        is_load = (o == lseu_pkg::OP_LOAD_DIRECT) || (o == lseu_pkg::OP_LOAD_INDIRECT) ||
                  (o == lseu_pkg::OP_LOAD_POST_INC) || (o == lseu_pkg::OP_LOAD_PRE_DEC) ||
                  (o == lseu_pkg::OP_LOAD_DISPLACED);
    endfunction : is_load

    function automatic logic is_prog(input lseu_pkg::lseu_op_t o);
        is_prog = (o == lseu_pkg::OP_READ_PROGRAM_MEM) || (o == lseu_pkg::OP_READ_PROGRAM_MEM_INC) ||
                  (o == lseu_pkg::OP_READ_PROGRAM_MEM_EXT) ||
                  (o == lseu_pkg::OP_READ_PROGRAM_MEM_EXT_INC);
    endfunction : is_prog

    assign sel_ptr = pick_ptr(ptr_sel, ptr_a, ptr_b, ptr_c);

    // pointer pairs kept beside the register file image
    lseu_ptr_file u_ptr_file (
        .clk      (clk),
        .rst_n    (rst_n),
        .wr_en    (ptr_wr),
        .wr_sel   (ptr_wr_sel),
        .wr_value (ptr_wr_value),
        .ptr_a    (ptr_a),
        .ptr_b    (ptr_b),
        .ptr_c    (ptr_c)
    );

    // pointer updates: pre-decrement at issue, post-increment at issue
    always_comb begin
        ptr_wr       = 1'b0;
        ptr_wr_sel   = ptr_sel;
        ptr_wr_value = sel_ptr;
        if (issue && state == PH_IDLE) begin
            unique case (new_op)
                lseu_pkg::OP_LOAD_POST_INC, lseu_pkg::OP_WRITE_POST_INC: begin
                    ptr_wr       = 1'b1;
                    ptr_wr_value = sel_ptr + 16'h0001;
                end
                lseu_pkg::OP_LOAD_PRE_DEC, lseu_pkg::OP_WRITE_PRE_DEC: begin
                    ptr_wr       = 1'b1;
                    ptr_wr_value = sel_ptr - 16'h0001;
                end
                lseu_pkg::OP_READ_PROGRAM_MEM_INC, lseu_pkg::OP_READ_PROGRAM_MEM_EXT_INC: begin
                    ptr_wr       = 1'b1;
                    ptr_wr_sel   = 2'(lseu_pkg::PTR_C);
                    ptr_wr_value = ptr_c + 16'h0001;
                end
                default: ;
            endcase
        end
    end

    // page extension register
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            program_page_ext <= lseu_pkg::RESET_PAGE_EXT;
        end else if (page_ext_wr) begin
            program_page_ext <= page_ext_value;
        end
    end

    // sequencing
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state    <= PH_IDLE;
            cur_op   <= lseu_pkg::OP_NONE;
            cur_ptr  <= 2'h0;
            cur_dest <= 5'h00;
            cycle    <= 2'h0;
            need     <= 2'h0;
            busy     <= 1'b0;
            done     <= 1'b0;
        end else begin
            done <= 1'b0;
            unique case (state)
                PH_IDLE: begin
                    if (issue && new_op != lseu_pkg::OP_NONE) begin
                        cur_op  <= new_op;
                        cur_ptr <= ptr_sel;
                        cur_dest <= (new_op == lseu_pkg::OP_READ_PROGRAM_MEM ||
                                     new_op == lseu_pkg::OP_READ_PROGRAM_MEM_EXT) &&
                                    dest_reg == lseu_pkg::REG_ZERO ? lseu_pkg::REG_ZERO : dest_reg;
                        need    <= cycles_of(new_op);
                        cycle   <= 2'h1;
                        busy    <= 1'b1;
                        state   <= PH_ACCESS;
                    end
                end
                PH_ACCESS: begin
                    // data waits stretch beyond the minimum count
                    if (!(data_wait && !is_prog(cur_op))) begin
                        if (cycle >= need) begin
                            state <= PH_FINISH;
                        end else begin
                            cycle <= cycle + 2'h1;
                        end
                    end
                end
                PH_FINISH: begin
                    busy  <= 1'b0;
                    done  <= 1'b1;
                    state <= PH_IDLE;
                end
            endcase
        end
    end

    // memory strobes and addresses, registered at issue
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            data_rd    <= 1'b0;
            data_wr    <= 1'b0;
            data_addr  <= 16'h0000;
            data_wdata <= 8'h00;
            prog_rd    <= 1'b0;
            prog_addr  <= 24'h000000;
        end else if (state == PH_IDLE && issue) begin
            data_rd <= is_load(new_op);
            data_wr <= (new_op == lseu_pkg::OP_WRITE_DIRECT_MEM) || (new_op == lseu_pkg::OP_WRITE_INDIRECT) ||
                       (new_op == lseu_pkg::OP_WRITE_POST_INC) || (new_op == lseu_pkg::OP_WRITE_PRE_DEC) ||
                       (new_op == lseu_pkg::OP_WRITE_DISPLACED);
            prog_rd    <= is_prog(new_op);
            data_wdata <= source_data;
            unique case (new_op)
                lseu_pkg::OP_LOAD_DIRECT, lseu_pkg::OP_WRITE_DIRECT_MEM:
                    data_addr <= abs_addr;
                lseu_pkg::OP_LOAD_PRE_DEC, lseu_pkg::OP_WRITE_PRE_DEC:
                    data_addr <= sel_ptr - 16'h0001;
                lseu_pkg::OP_LOAD_DISPLACED, lseu_pkg::OP_WRITE_DISPLACED:
                    data_addr <= sel_ptr + {10'h000, displacement};
                default:
                    data_addr <= sel_ptr;
            endcase
            if (new_op == lseu_pkg::OP_READ_PROGRAM_MEM_EXT || new_op == lseu_pkg::OP_READ_PROGRAM_MEM_EXT_INC) begin
                prog_addr <= {program_page_ext, ptr_c};
            end else begin
                prog_addr <= {8'h00, ptr_c};
            end
        end else if (state == PH_ACCESS && cycle >= need && !(data_wait && !is_prog(cur_op))) begin
            data_rd <= 1'b0;
            data_wr <= 1'b0;
            prog_rd <= 1'b0;
        end
    end

    // register write-back; flags never touched
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            reg_wr      <= 1'b0;
            reg_wr_addr <= 5'h00;
            reg_wr_data <= 8'h00;
        end else if (state == PH_ACCESS && cycle >= need && !(data_wait && !is_prog(cur_op)) &&
                     (is_load(cur_op) || is_prog(cur_op))) begin
            reg_wr      <= 1'b1;
            reg_wr_addr <= cur_dest;
            reg_wr_data <= is_prog(cur_op) ? prog_rdata : data_rdata;
        end else begin
            reg_wr <= 1'b0;
        end
    end
endmodule : lseu_core

// [core/lseu_pkg.sv]
package lseu_pkg;
    // operation codes presented by the instruction decoder
    typedef enum logic [3:0] {
        OP_NONE,
        OP_LOAD_DIRECT,
        OP_LOAD_INDIRECT,
        OP_LOAD_POST_INC,
        OP_LOAD_PRE_DEC,
        OP_LOAD_DISPLACED,
        OP_WRITE_DIRECT_MEM,
        OP_WRITE_INDIRECT,
        OP_WRITE_POST_INC,
        OP_WRITE_PRE_DEC,
        OP_WRITE_DISPLACED,
        OP_READ_PROGRAM_MEM,
        OP_READ_PROGRAM_MEM_INC,
        OP_READ_PROGRAM_MEM_EXT,
        OP_READ_PROGRAM_MEM_EXT_INC
    } lseu_op_t;

    // pointer selection
    typedef enum logic [1:0] {
        PTR_A,
        PTR_B,
        PTR_C
    } lseu_ptr_t;

    // minimum cycle counts per form
    localparam int CYC_DIRECT    = 2;
    localparam int CYC_INDIRECT  = 1;
    localparam int CYC_PRE_DEC   = 2;
    localparam int CYC_DISPLACED = 2;
    localparam int CYC_PROGRAM   = 3;

    // register file indices of the pointer pairs, low byte first
    localparam logic [4:0] REG_PTR_A_LO = 5'h1A;
    localparam logic [4:0] REG_PTR_B_LO = 5'h1C;
    localparam logic [4:0] REG_PTR_C_LO = 5'h1E;
    localparam logic [4:0] REG_ZERO     = 5'h00;

    localparam logic [7:0] RESET_PAGE_EXT = 8'h00;
endpackage : lseu_pkg

// [core/lseu_ptr_file.sv]
`timescale 1ns/1ps
// pointer register pairs 27:26, 29:28, 31:30 with single-port update
module lseu_ptr_file (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rst_n,
    // update port
    input  wire logic        wr_en,
    input  wire logic [1:0]  wr_sel,
    input  wire logic [15:0] wr_value,
    // read out
    output logic [15:0]      ptr_a,
    output logic [15:0]      ptr_b,
    output logic [15:0]      ptr_c
);
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ptr_a <= 16'h0000;
            ptr_b <= 16'h0000;
            ptr_c <= 16'h0000;
        end else if (wr_en) begin
            unique case (lseu_pkg::lseu_ptr_t'(wr_sel))
                lseu_pkg::PTR_A: ptr_a <= wr_value;
                lseu_pkg::PTR_B: ptr_b <= wr_value;
                lseu_pkg::PTR_C: ptr_c <= wr_value;
                default: ;
            endcase
        end
    end
endmodule : lseu_ptr_file

// [verif/lseu_mem_model.sv]
`timescale 1ns/1ps
module lseu_mem_model (
    // access side
    input  wire logic        clk,
    input  wire logic        data_rd,
    input  wire logic        data_wr,
    input  wire logic [15:0] data_addr,
    input  wire logic [7:0]  data_wdata,
    input  wire logic        prog_rd,
    input  wire logic [23:0] prog_addr,
    // stall depth per access, from the bench
    input  wire logic [1:0]  stall,
    // answers
    output logic [7:0]       data_rdata,
    output logic             data_wait,
    output logic [7:0]       prog_rdata,
    output logic [23:0]      wr_seen
);
    logic [1:0] cnt = 2'h0;
    wire acc = data_rd | data_wr;
    // slow target stretches each data access; program reads are never stretched
    assign data_wait = acc && cnt < stall;
    // undriven bus shows the inverse pattern
    assign data_rdata = data_rd ? data_addr[7:0] ^ 8'hA5 : ~(data_addr[7:0] ^ 8'hA5);
    assign prog_rdata = prog_rd ? prog_addr[7:0] ^ prog_addr[23:16] : ~prog_addr[7:0];
    always_ff @(posedge clk) begin
        cnt <= !acc ? 2'h0 : data_wait ? cnt + 2'h1 : cnt;
    end
    always_ff @(posedge clk) begin
        if (data_wr && !data_wait) wr_seen <= {data_addr, data_wdata};
    end
endmodule : lseu_mem_model

// [verif/lseu_core_monitor.sv]
`timescale 1ns/1ps
module lseu_core_monitor (
    // watched ports
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        issue,
    input  wire logic [3:0]  op,
    input  wire logic [15:0] abs_addr,
    input  wire logic [7:0]  source_data,
    input  wire logic        page_ext_wr,
    input  wire logic [7:0]  page_ext_value,
    input  wire logic        busy,
    input  wire logic        done,
    input  wire logic        reg_wr,
    input  wire logic [7:0]  program_page_ext,
    input  wire logic        data_rd,
    input  wire logic        data_wr,
    input  wire logic [15:0] data_addr,
    input  wire logic [7:0]  data_wdata,
    input  wire logic        data_wait,
    input  wire logic        prog_rd,
    input  wire logic [23:0] prog_addr
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    logic [3:0] lat = 4'h0;
    logic [2:0] acc_n;
    logic [2:0] prog_n;
    logic [2:0] want;
    wire take = issue && !busy;
    always_comb begin
        case (lat)
            4'h2, 4'h3, 4'h7, 4'h8: want = 3'(lseu_pkg::CYC_INDIRECT);
            default: want = 3'(lseu_pkg::CYC_DIRECT);
        endcase
    end
    // unstalled access cycles of the current op
    always_ff @(posedge clk) begin
        if (!rst_n || take) begin
            acc_n <= 3'h0;
            prog_n <= 3'h0;
        end else begin
            acc_n <= acc_n + 3'((data_rd | data_wr) && !data_wait);
            prog_n <= prog_n + 3'(prog_rd);
        end
    end
    always_ff @(posedge clk) begin
        if (take) lat <= op;
    end
    access_len_a: assert property ($fell(data_rd | data_wr) |-> acc_n == want)
        else $error("data access length wrong");
    prog_len_a: assert property ($fell(prog_rd) |-> prog_n == 3'(lseu_pkg::CYC_PROGRAM))
        else $error("program read length wrong");
    direct_load_a: assert property (take && op == 4'h1 |=> data_rd && data_addr == $past(abs_addr))
        else $error("direct load address wrong");
    direct_store_a: assert property (take && op == 4'h6 |=> data_wr && data_addr == $past(abs_addr)
        && data_wdata == $past(source_data)) else $error("direct store wrong");
    ext_page_a: assert property (take && op inside {4'hD, 4'hE} |=> prog_rd
        && prog_addr[23:16] == program_page_ext) else $error("extended page missing");
    page_load_a: assert property (page_ext_wr |=> program_page_ext == $past(page_ext_value))
        else $error("page extension not loaded");
    wb_done_a: assert property (reg_wr |=> done)
        else $error("write-back not followed by done");
    store_quiet_a: assert property (data_wr |-> !reg_wr)
        else $error("store wrote a register");
    done_idle_a: assert property (done |-> !busy && !data_rd && !data_wr && !prog_rd)
        else $error("done while still accessing");
    cover property (take && op == 4'hE);
    cover property ($rose(data_wait));
    cover property (take && op == 4'h9);
endmodule : lseu_core_monitor
bind lseu_core lseu_core_monitor mon (.clk, .rst_n, .issue, .op, .abs_addr, .source_data, .page_ext_wr,
    .page_ext_value, .busy, .done, .reg_wr, .program_page_ext, .data_rd, .data_wr, .data_addr, .data_wdata,
    .data_wait, .prog_rd, .prog_addr);

// [verif/tb_top.sv]
`timescale 1ns/1ps
module tb_top;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic issue = 1'b0;
    logic page_ext_wr = 1'b0;
    logic busy, done, reg_wr, data_rd, data_wr, data_wait, prog_rd;
    logic [3:0] op = 4'h0;
    logic [1:0] ptr_sel = 2'h0;
    logic [1:0] stall = 2'h0;
    logic [4:0] dest_reg = 5'h00;
    logic [4:0] reg_wr_addr;
    logic [15:0] abs_addr = 16'h0000;
    logic [15:0] data_addr;
    logic [5:0] displacement = 6'h00;
    logic [7:0] source_data = 8'h00;
    logic [7:0] page_ext_value = 8'h00;
    logic [7:0] reg_wr_data, program_page_ext, data_wdata, data_rdata, prog_rdata;
    logic [23:0] prog_addr, wr_seen, sa;
    logic [12:0] wb;
    logic [15:0] ptr [3] = '{16'h0000, 16'h0000, 16'h0000};
    int n_fail = 0;
    int checked = 0;
    int cyc;
    lseu_core dut (.clk, .rst_n, .issue, .op, .ptr_sel, .dest_reg, .source_reg(5'h03), .abs_addr, .displacement,
        .source_data, .page_ext_wr, .page_ext_value, .busy, .done, .reg_wr, .reg_wr_addr, .reg_wr_data,
        .program_page_ext, .data_rd, .data_wr, .data_addr, .data_wdata, .data_rdata, .data_wait, .prog_rd,
        .prog_addr, .prog_rdata);
    lseu_mem_model mem (.clk, .data_rd, .data_wr, .data_addr, .data_wdata, .prog_rd, .prog_addr, .stall,
        .data_rdata, .data_wait, .prog_rdata, .wr_seen);
    initial begin
        forever #50 clk = ~clk;
    end
    task automatic check(string what, logic [23:0] seen, logic [23:0] exp);
        checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : conclude
    // minimum cycle count of each form, unstretched
    function automatic int min_cycles(lseu_pkg::lseu_op_t o);
        case (o)
            lseu_pkg::OP_LOAD_INDIRECT, lseu_pkg::OP_LOAD_POST_INC, lseu_pkg::OP_WRITE_INDIRECT,
            lseu_pkg::OP_WRITE_POST_INC: min_cycles = lseu_pkg::CYC_INDIRECT;
            lseu_pkg::OP_LOAD_PRE_DEC, lseu_pkg::OP_WRITE_PRE_DEC: min_cycles = lseu_pkg::CYC_PRE_DEC;
            lseu_pkg::OP_LOAD_DISPLACED, lseu_pkg::OP_WRITE_DISPLACED: min_cycles = lseu_pkg::CYC_DISPLACED;
            lseu_pkg::OP_LOAD_DIRECT, lseu_pkg::OP_WRITE_DIRECT_MEM: min_cycles = lseu_pkg::CYC_DIRECT;
            default: min_cycles = lseu_pkg::CYC_PROGRAM;
        endcase
    endfunction : min_cycles
    task automatic run(lseu_pkg::lseu_op_t o, logic [1:0] p, logic [5:0] d, logic [15:0] a);
        @(negedge clk);
        op = o;
        ptr_sel = p;
        displacement = d;
        abs_addr = a;
        issue = 1'b1;
        @(negedge clk);
        issue = 1'b0;
        sa = 24'hFFFFFF;
        wb = 13'h0000;
        for (cyc = 1; cyc < 20 && done !== 1'b1; cyc++) begin
            if (cyc == 1) check("busy", {23'h000000, busy}, 24'h000001);
            if ((data_rd | data_wr) === 1'b1 && sa === 24'hFFFFFF) sa = {8'h00, data_addr};
            if (prog_rd === 1'b1 && sa === 24'hFFFFFF) sa = prog_addr;
            if (reg_wr === 1'b1) wb = {reg_wr_addr, reg_wr_data};
            @(negedge clk);
        end
        if (cyc == 20) begin
            n_fail++;
            conclude();
        end
        check("busy at done", {23'h000000, busy}, 24'h000000);
        check("op length", 24'(cyc), 24'(min_cycles(o) + 2 + int'(stall)));
    endtask : run
    task automatic load(lseu_pkg::lseu_op_t o, logic [1:0] p, logic [5:0] d, logic [23:0] ea);
        run(o, p, d, o == lseu_pkg::OP_LOAD_DIRECT ? ea[15:0] : ~ea[15:0]);
        check("load address", sa, ea);
        check("load result", {11'h000, wb}, {11'h000, dest_reg, ea[7:0] ^ 8'hA5});
    endtask : load
    task automatic store(lseu_pkg::lseu_op_t o, logic [1:0] p, logic [5:0] d, logic [23:0] ea, logic [7:0] v);
        source_data = v;
        run(o, p, d, o == lseu_pkg::OP_WRITE_DIRECT_MEM ? ea[15:0] : ~ea[15:0]);
        check("stored byte", wr_seen, {ea[15:0], v});
        check("store write-back", {11'h000, wb}, 24'h000000);
    endtask : store
    task automatic t_direct();
        dest_reg = 5'h05;
        load(lseu_pkg::OP_LOAD_DIRECT, 2'h0, 6'h00, 24'h001234);
        store(lseu_pkg::OP_WRITE_DIRECT_MEM, 2'h0, 6'h00, 24'h00BEEF, 8'h3C);
    endtask : t_direct
    task automatic t_pointer();
        for (int i = 0; i < 3; i++) begin
            load(lseu_pkg::OP_LOAD_POST_INC, 2'(i), 6'h00, {8'h00, ptr[i]});
            ptr[i] = ptr[i] + 16'h0001;
            store(lseu_pkg::OP_WRITE_POST_INC, 2'(i), 6'h00, {8'h00, ptr[i]}, 8'h40);
            ptr[i] = ptr[i] + 16'h0001;
            load(lseu_pkg::OP_LOAD_INDIRECT, 2'(i), 6'h00, {8'h00, ptr[i]});
            store(lseu_pkg::OP_WRITE_INDIRECT, 2'(i), 6'h00, {8'h00, ptr[i]}, 8'h81);
            ptr[i] = ptr[i] - 16'h0001;
            load(lseu_pkg::OP_LOAD_PRE_DEC, 2'(i), 6'h00, {8'h00, ptr[i]});
            ptr[i] = ptr[i] - 16'h0001;
            store(lseu_pkg::OP_WRITE_PRE_DEC, 2'(i), 6'h00, {8'h00, ptr[i]}, 8'hC2);
        end
        ptr[0] = ptr[0] - 16'h0001;
        load(lseu_pkg::OP_LOAD_PRE_DEC, 2'h0, 6'h00, {8'h00, ptr[0]});
    endtask : t_pointer
    task automatic t_displaced();
        load(lseu_pkg::OP_LOAD_DISPLACED, 2'h1, 6'h3F, {8'h00, ptr[1] + 16'h003F});
        store(lseu_pkg::OP_WRITE_DISPLACED, 2'h2, 6'h01, {8'h00, ptr[2] + 16'h0001}, 8'h5E);
        load(lseu_pkg::OP_LOAD_INDIRECT, 2'h1, 6'h00, {8'h00, ptr[1]});
        load(lseu_pkg::OP_LOAD_INDIRECT, 2'h2, 6'h00, {8'h00, ptr[2]});
    endtask : t_displaced
    task automatic t_program();
        lseu_pkg::lseu_op_t pops [4] = '{lseu_pkg::OP_READ_PROGRAM_MEM, lseu_pkg::OP_READ_PROGRAM_MEM_INC,
            lseu_pkg::OP_READ_PROGRAM_MEM_EXT, lseu_pkg::OP_READ_PROGRAM_MEM_EXT_INC};
        logic [7:0] pg;
        @(negedge clk);
        page_ext_wr = 1'b1;
        page_ext_value = 8'h5A;
        @(negedge clk);
        page_ext_wr = 1'b0;
        check("page extension", {16'h0000, program_page_ext}, 24'h00005A);
        for (int i = 0; i < 4; i++) begin
            dest_reg = i[0] ? 5'h07 : 5'h00;
            run(pops[i], 2'h2, 6'h00, 16'h0000);
            pg = (i > 1) ? 8'h5A : 8'h00;
            check("flash address", sa, {pg, ptr[2]});
            check("flash byte", {11'h000, wb}, {11'h000, dest_reg, ptr[2][7:0] ^ pg});
            if (i[0]) ptr[2]++;
        end
    endtask : t_program
    task automatic t_stretch();
        int base;
        load(lseu_pkg::OP_LOAD_INDIRECT, 2'h0, 6'h00, {8'h00, ptr[0]});
        base = cyc;
        stall = 2'h2;
        load(lseu_pkg::OP_LOAD_INDIRECT, 2'h0, 6'h00, {8'h00, ptr[0]});
        stall = 2'h0;
        check("stretched length", 24'(cyc - base), 24'h000002);
    endtask : t_stretch
    initial begin
        repeat (10) @(negedge clk);
        rst_n = 1'b1;
        t_direct();
        t_pointer();
        t_displaced();
        t_program();
        t_stretch();
        conclude();
    end
endmodule : tb_top
